// >>> common/picu_pkg.sv
// picu_pkg: constants, types and register map of the priority interrupt
// controller. Assumes one clock (pclk) and an APB register port.
package picu_pkg;

  // register byte offsets on the APB port
  localparam logic [7:0] REG_SYSCTL = 8'h00; // system_control_reg
  localparam logic [7:0] REG_CCR = 8'h04; // condition_code_reg
  localparam logic [7:0] REG_PRIO_A = 8'h08; // priority_reg_a
  localparam logic [7:0] REG_PRIO_B = 8'h0C; // priority_reg_b
  localparam logic [7:0] REG_EN_LO = 8'h10; // enables, vectors 0..31
  localparam logic [7:0] REG_EN_HI = 8'h14; // enables, vectors 32..63
  localparam logic [7:0] REG_PEND_LO = 8'h18; // pending, read only
  localparam logic [7:0] REG_PEND_HI = 8'h1C; // pending, read only
  localparam logic [7:0] REG_STATUS = 8'h20; // sequencer state, read only

  // system_control_reg fields
  localparam int SC_MM_BIT = 0; // mask_mode_select
  localparam int SC_ADV_BIT = 1; // advanced (4-byte) vector mode
  localparam int SC_MT_LSB = 2; // memory type, 2 bits
  localparam int SC_WT_LSB = 4; // wait states per access, 4 bits
  localparam logic [7:0] SYSCTL_RST = 8'h03;

  // condition_code_reg fields
  localparam int CCR_I_BIT = 0; // global mask flag
  localparam int CCR_UI_BIT = 1; // second_mask_flag
  localparam logic [1:0] CCR_RST = 2'h1;

  // status register fields
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_NMI_BIT = 9;

  // vector numbers
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_IRQ0 = 6'h0C;
  localparam int NUM_PINS = 6;
  // maskable sources that exist; serial 0 at 52..55, serial 1 at 56..59,
  // 60..63 reserved and never requested
  localparam logic [63:0] VALID_SRC = 64'h0FF00FF7_7793F000;

  // memory types and access lengths in states
  localparam logic [1:0] MT_16_2ST = 2'h0; // also on-chip memory
  localparam logic [1:0] MT_16_3ST = 2'h1;
  localparam logic [1:0] MT_8_2ST = 2'h2;
  localparam logic [1:0] MT_8_3ST = 2'h3;
  localparam logic [4:0] ACC_16_2ST = 5'h04;
  localparam logic [4:0] ACC_16_3ST = 5'h06;
  localparam logic [4:0] ACC_8_2ST = 5'h08;
  localparam logic [4:0] ACC_8_3ST = 5'h0C;
  localparam logic [4:0] INT_AFTER_ACCEPT = 5'h02;
  localparam logic [4:0] INT_AFTER_VECTOR = 5'h02;

  typedef enum logic [2:0] {
    PICU_IDLE, PICU_WAIT_INSN, PICU_INT_A, PICU_STACK,
    PICU_VECTOR, PICU_INT_B, PICU_FETCH
  } picu_state_t;

  // everything the controller drives toward the cpu core except ccr_flags
  typedef struct packed {
    logic int_req; // asks the core to end its instruction
    logic stack_wr; // pulse: push stack_pc and stack_ccr
    logic vec_rd; // pulse: read vector at vec_addr
    logic fetch_rd; // pulse: prefetch at handler_addr
    logic handler_go; // pulse: first handler instruction may run
    logic [5:0] ack_vec; // vector number being served
    logic [15:0] vec_addr;
    logic [23:0] stack_pc;
    logic [7:0] stack_ccr;
    logic [23:0] handler_addr;
  } picu_cpu_out_t;

endpackage

// >>> hw/picu_top.sv
// picu_top: priority interrupt controller with apb registers and the
// exception sequencer toward the cpu core.
// Assumes pins and core handshakes are synchronous to pclk.
//
// Notes on behaviour
// R1: serial 0 sources at vectors 52-55, one bit
// R2: serial 1 at 56-59, lower bit; 60-63 reserved
// R3: mask_mode_select 1 uses only the global flag
// R4: nonmaskable always accepted except reset or standby
// R5: source forwarded only while its enable is 1
// R6: highest level wins, ties to lower vector
// R7: level 1 served ahead of level 0
// R8: single-mask mode, flag set: only nonmaskable accepted
// R9: two-bit mode: level 0 masked by global flag
// R10: two-bit mode: level 1 masked when both set
// R11: two-bit mode: flag clear accepts everything
// R12: flag 1, second 0: only level 1 accepted
// R13: sequence starts after current instruction ends
// R14: push counter and condition codes to stack
// R15: single-mask mode sets global flag after stacking
// R16: two-bit mode sets both flags after stacking
// R17: form vector address, read it, jump there
// R18: decision: 2 states external, 1 internal
// R19: access length set by memory type
// R20: internal processing totals 4 states
// R21: wait states lengthen every access phase
// R22: reset gives fixed order; nonmaskable not programmable
// R23: pending holds until accepted or source drops
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module picu_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request sources
  input wire logic nmi_pin,
  input wire logic [picu_pkg::NUM_PINS-1:0] irq_pin,
  input wire logic [63:0] periph_req,
  input wire logic hw_standby,
  // cpu core side
  input wire logic instr_done,
  input wire logic [23:0] cpu_pc,
  input wire logic [23:0] vec_rdata,
  output picu_pkg::picu_cpu_out_t cpu_out,
  output logic [1:0] ccr_flags
);

  // decoding of the priority bit that serves a vector: {hit, index}
  function automatic logic [4:0] ipr_of(input logic [5:0] v);
    logic [4:0] r;
    r = 5'h00;
    case (v)
      6'h0C: r = 5'h1F;
      6'h0D: r = 5'h1E;
      6'h0E, 6'h0F: r = 5'h1D;
      6'h10, 6'h11: r = 5'h1C;
      6'h14: r = 5'h1B;
      6'h18, 6'h19, 6'h1A: r = 5'h1A;
      6'h1C, 6'h1D, 6'h1E: r = 5'h19;
      6'h20, 6'h21, 6'h22: r = 5'h18;
      6'h24, 6'h25, 6'h26, 6'h27: r = 5'h17;
      6'h28, 6'h29, 6'h2A, 6'h2B: r = 5'h16;
      6'h34, 6'h35, 6'h36, 6'h37: r = 5'h13; // [R1]
      6'h38, 6'h39, 6'h3A, 6'h3B: r = 5'h12; // [R2]
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // access length of one bus phase for a memory type
  function automatic logic [4:0] acc_len(input logic [1:0] mt);
    logic [4:0] r;
    r = picu_pkg::ACC_16_2ST;
    case (mt)
      picu_pkg::MT_16_2ST: r = picu_pkg::ACC_16_2ST;
      picu_pkg::MT_16_3ST: r = picu_pkg::ACC_16_3ST;
      picu_pkg::MT_8_2ST: r = picu_pkg::ACC_8_2ST;
      picu_pkg::MT_8_3ST: r = picu_pkg::ACC_8_3ST;
      default: r = picu_pkg::ACC_16_2ST;
    endcase
    return r;
  endfunction

  // registers
  logic [7:0] sysctl_reg;
  logic [1:0] ccr_reg, ccr_next;
  logic [7:0] prio_a_reg, prio_b_reg;
  logic [63:0] en_reg;
  logic [63:0] pend_reg, pend_next;
  logic [picu_pkg::NUM_PINS-1:0] pin_stage_reg;
  logic nmi_stage_reg, nmi_prev_reg, nmi_pend_reg, nmi_pend_next;
  picu_pkg::picu_state_t state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [5:0] vec_reg, vec_next;
  logic serving_nmi_reg, serving_nmi_next;
  picu_pkg::picu_cpu_out_t out_reg, out_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pslverr_reg, pslverr_next;

  // apb decode: one setup cycle, answer in the first access cycle
  wire logic [7:0] addr = paddr[7:0];
  wire logic setup = psel & ~penable;
  wire logic wr_en = psel & penable & pready_reg & pwrite;
  wire logic wr_sysctl = wr_en & (addr == picu_pkg::REG_SYSCTL);
  wire logic wr_ccr = wr_en & (addr == picu_pkg::REG_CCR);
  wire logic wr_prio_a = wr_en & (addr == picu_pkg::REG_PRIO_A);
  wire logic wr_prio_b = wr_en & (addr == picu_pkg::REG_PRIO_B);
  wire logic wr_en_lo = wr_en & (addr == picu_pkg::REG_EN_LO);
  wire logic wr_en_hi = wr_en & (addr == picu_pkg::REG_EN_HI);
  wire logic is_ro = (addr == picu_pkg::REG_PEND_LO) |
                     (addr == picu_pkg::REG_PEND_HI) |
                     (addr == picu_pkg::REG_STATUS);
  wire logic is_rw = (addr == picu_pkg::REG_SYSCTL) |
                     (addr == picu_pkg::REG_CCR) |
                     (addr == picu_pkg::REG_PRIO_A) |
                     (addr == picu_pkg::REG_PRIO_B) |
                     (addr == picu_pkg::REG_EN_LO) |
                     (addr == picu_pkg::REG_EN_HI);
  wire logic bad_addr = ~(is_rw | is_ro) | (paddr[1:0] != 2'h0) |
                        (paddr[31:8] != 24'h000000);

  // system control fields
  wire logic mm_sel = sysctl_reg[picu_pkg::SC_MM_BIT];
  wire logic adv_mode = sysctl_reg[picu_pkg::SC_ADV_BIT];
  wire logic [1:0] mem_type = sysctl_reg[picu_pkg::SC_MT_LSB +: 2];
  wire logic [3:0] wait_st = sysctl_reg[picu_pkg::SC_WT_LSB +: 4];
  wire logic flag_i = ccr_reg[picu_pkg::CCR_I_BIT];
  wire logic flag_ui = ccr_reg[picu_pkg::CCR_UI_BIT];
  wire logic [15:0] prio_bits = {prio_a_reg, prio_b_reg};

  // raw requests per vector: pins pass one extra stage, which gives
  // external sources their second decision state
  logic [63:0] raw_req;
  logic [63:0] lvl1;
  genvar gv;
  generate
    for (gv = 0; gv < 64; gv++) begin : g_vec
      localparam logic [5:0] V = 6'(gv);
      localparam logic [4:0] IP = ipr_of(V);
      if (gv >= 12 && gv < 12 + picu_pkg::NUM_PINS) begin : g_pin
        assign raw_req[gv] = pin_stage_reg[gv - 12]; // [R18]
      end else begin : g_per
        assign raw_req[gv] = periph_req[gv]; // [R18]
      end
      // unprogrammed sources and reset values give level 0 [R22]
      assign lvl1[gv] = IP[4] & prio_bits[IP[3:0]];
    end
  endgenerate

  // a source enters the pending bits only while enabled; 60..63 never do
  wire logic [63:0] fwd_req = raw_req & en_reg & picu_pkg::VALID_SRC; // [R5]

  // selection: level 1 first, then lowest vector number
  wire logic [63:0] cand1 = pend_reg & lvl1;
  wire logic any1 = |cand1;
  wire logic [63:0] cand = any1 ? cand1 : pend_reg; // [R7]
  logic [5:0] sel_vec;
  always_comb begin
    sel_vec = 6'h00;
    for (int k = 63; k >= 0; k--) begin
      if (cand[k]) begin
        sel_vec = 6'(k); // lowest index wins the tie [R6]
      end
    end
  end
  wire logic any_pend = |pend_reg;

  // masking; with mask_mode_select at 1 the second flag is ignored [R3]
  // [R8] [R9] [R10] [R11] [R12]
  wire logic sel_ok = ~flag_i | (~mm_sel & ~flag_ui & any1);
  wire logic take_mask = any_pend & sel_ok;
  wire logic take_nmi = nmi_pend_reg & ~hw_standby; // no mask applies [R4]
  wire logic idle = (state_reg == picu_pkg::PICU_IDLE);
  wire logic accept = idle & (take_nmi | take_mask);
  wire logic [5:0] acc_vec = take_nmi ? picu_pkg::VEC_NMI : sel_vec;
  wire logic [63:0] clr_mask = (accept & ~take_nmi) ?
                               (64'h1 << sel_vec) : 64'h0;

  // pending bits: a new request beats the accept clear of the same cycle,
  // and a source that drops its request withdraws it [R23]
  assign pend_next = ((pend_reg & ~clr_mask) | fwd_req) & raw_req;

  // nonmaskable edge; dropped in standby so none is served there [R4]
  wire logic nmi_rise = nmi_stage_reg & ~nmi_prev_reg;
  assign nmi_pend_next = ~hw_standby &
                         (nmi_rise | (nmi_pend_reg & ~(accept & take_nmi)));

  // vector address: 4-byte entries in advanced mode, else 2-byte
  wire logic [15:0] vaddr = adv_mode ? {8'h00, vec_reg, 2'h0}
                                     : {9'h000, vec_reg, 1'b0}; // [R17]
  // one bus phase, stretched by wait states [R19] [R21]
  wire logic [4:0] phase_len = acc_len(mem_type) + {1'b0, wait_st};

  // exception sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    vec_next = vec_reg;
    serving_nmi_next = serving_nmi_reg;
    ccr_next = ccr_reg;
    out_next = out_reg;
    out_next.stack_wr = 1'b0;
    out_next.vec_rd = 1'b0;
    out_next.fetch_rd = 1'b0;
    out_next.handler_go = 1'b0;
    if (wr_ccr) begin
      ccr_next = pwdata[1:0];
    end
    case (state_reg)
      picu_pkg::PICU_IDLE: begin
        if (accept) begin
          vec_next = acc_vec;
          serving_nmi_next = take_nmi;
          out_next.int_req = 1'b1;
          out_next.ack_vec = acc_vec;
          state_next = picu_pkg::PICU_WAIT_INSN;
        end
      end
      picu_pkg::PICU_WAIT_INSN: begin
        // the core finishes its instruction first [R13]
        if (instr_done) begin
          out_next.int_req = 1'b0;
          out_next.stack_pc = cpu_pc; // resume address [R14]
          out_next.stack_ccr = {6'h00, ccr_reg};
          cnt_next = picu_pkg::INT_AFTER_ACCEPT - 5'h01;
          state_next = picu_pkg::PICU_INT_A;
        end
      end
      picu_pkg::PICU_INT_A: begin
        // two states here and two after the vector make four [R20]
        if (cnt_reg == 5'h00) begin
          out_next.stack_wr = 1'b1; // push pc and ccr [R14]
          cnt_next = phase_len - 5'h01;
          state_next = picu_pkg::PICU_STACK;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      picu_pkg::PICU_STACK: begin
        if (cnt_reg == 5'h00) begin
          // mask update after stacking wins over a software write
          ccr_next[picu_pkg::CCR_I_BIT] = 1'b1; // [R15] [R16]
          if (!mm_sel) begin
            ccr_next[picu_pkg::CCR_UI_BIT] = 1'b1; // [R16]
          end
          out_next.vec_addr = vaddr; // [R17]
          out_next.vec_rd = 1'b1;
          cnt_next = phase_len - 5'h01;
          state_next = picu_pkg::PICU_VECTOR;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      picu_pkg::PICU_VECTOR: begin
        if (cnt_reg == 5'h00) begin
          out_next.handler_addr = vec_rdata; // start address [R17]
          cnt_next = picu_pkg::INT_AFTER_VECTOR - 5'h01;
          state_next = picu_pkg::PICU_INT_B;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      picu_pkg::PICU_INT_B: begin
        if (cnt_reg == 5'h00) begin
          out_next.fetch_rd = 1'b1;
          cnt_next = phase_len - 5'h01;
          state_next = picu_pkg::PICU_FETCH;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      picu_pkg::PICU_FETCH: begin
        if (cnt_reg == 5'h00) begin
          out_next.handler_go = 1'b1; // [R17]
          state_next = picu_pkg::PICU_IDLE;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      default: begin
        state_next = picu_pkg::PICU_IDLE;
      end
    endcase
  end

  // read data, prepared in the setup cycle
  always_comb begin
    prdata_next = 32'h00000000;
    case (addr)
      picu_pkg::REG_SYSCTL: prdata_next = {24'h000000, sysctl_reg};
      picu_pkg::REG_CCR: prdata_next = {30'h00000000, ccr_reg};
      picu_pkg::REG_PRIO_A: prdata_next = {24'h000000, prio_a_reg};
      picu_pkg::REG_PRIO_B: prdata_next = {24'h000000, prio_b_reg};
      picu_pkg::REG_EN_LO: prdata_next = en_reg[31:0];
      picu_pkg::REG_EN_HI: prdata_next = en_reg[63:32];
      picu_pkg::REG_PEND_LO: prdata_next = pend_reg[31:0];
      picu_pkg::REG_PEND_HI: prdata_next = pend_reg[63:32];
      picu_pkg::REG_STATUS: prdata_next = {22'h000000, serving_nmi_reg,
                                           ~idle, 2'h0, vec_reg};
      default: prdata_next = 32'h00000000;
    endcase
    if (bad_addr) begin
      prdata_next = 32'h00000000;
    end
  end
  assign pslverr_next = bad_addr | (pwrite & is_ro);

  // apb answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & pslverr_next;
      prdata_reg <= setup ? prdata_next : 32'h00000000;
    end
  end

  // software registers; enables and priorities steer the selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysctl_reg <= picu_pkg::SYSCTL_RST;
      prio_a_reg <= 8'h00; // fixed default order after reset [R22]
      prio_b_reg <= 8'h00;
      en_reg <= 64'h0;
    end else begin
      if (wr_sysctl) sysctl_reg <= pwdata[7:0];
      if (wr_prio_a) prio_a_reg <= pwdata[7:0];
      if (wr_prio_b) prio_b_reg <= pwdata[7:0];
      if (wr_en_lo) en_reg[31:0] <= pwdata;
      if (wr_en_hi) en_reg[63:32] <= pwdata;
    end
  end

  // request capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_stage_reg <= '0;
      nmi_stage_reg <= 1'b0;
      nmi_prev_reg <= 1'b0;
      nmi_pend_reg <= 1'b0;
      pend_reg <= 64'h0;
    end else begin
      pin_stage_reg <= irq_pin;
      nmi_stage_reg <= nmi_pin;
      nmi_prev_reg <= nmi_stage_reg;
      nmi_pend_reg <= nmi_pend_next;
      pend_reg <= pend_next;
    end
  end

  // sequencer state; the core resets with the global flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= picu_pkg::PICU_IDLE;
      cnt_reg <= 5'h00;
      vec_reg <= 6'h00;
      serving_nmi_reg <= 1'b0;
      ccr_reg <= picu_pkg::CCR_RST;
      out_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      vec_reg <= vec_next;
      serving_nmi_reg <= serving_nmi_next;
      ccr_reg <= ccr_next;
      out_reg <= out_next;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cpu_out = out_reg;
  assign ccr_flags = ccr_reg;

endmodule

// >>> sim/picu_monitor.sv
// picu_monitor: concurrent checks on the controller's ports.
// Assumes one clock; tracks system_control_reg from apb writes.
`timescale 1ns/1ps
module picu_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // core side
  input wire logic hw_standby,
  input wire logic instr_done,
  input wire logic [23:0] cpu_pc,
  input wire picu_pkg::picu_cpu_out_t cpu_out,
  input wire logic [1:0] ccr_flags
);
  logic [7:0] sc_reg;
  logic [4:0] gap_reg;
  logic [23:0] pc_reg;
  logic [1:0] cc_reg;
  // named views of the core handshakes
  wire req = cpu_out.int_req;
  wire stk = cpu_out.stack_wr;
  wire vrd = cpu_out.vec_rd;
  wire frd = cpu_out.fetch_rd;
  wire nmi = cpu_out.ack_vec == picu_pkg::VEC_NMI;
  wire sc_wr = psel && penable && pready && pwrite &&
    paddr == {24'h000000, picu_pkg::REG_SYSCTL};
  wire [1:0] mt = sc_reg[3:2];
  wire [4:0] alen = mt == 2'h0 ? picu_pkg::ACC_16_2ST :
    mt == 2'h1 ? picu_pkg::ACC_16_3ST :
    mt == 2'h2 ? picu_pkg::ACC_8_2ST : picu_pkg::ACC_8_3ST;
  wire [4:0] plen = alen + {1'b0, sc_reg[7:4]};
  // shadow state; gap counts cycles since the last phase pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_reg <= picu_pkg::SYSCTL_RST;
      gap_reg <= 5'h00;
      pc_reg <= 24'h000000;
      cc_reg <= 2'h0;
    end else begin
      if (sc_wr) sc_reg <= pwdata[7:0];
      gap_reg <= (stk || vrd || frd) ? 5'h01 : gap_reg + 5'h01;
      if (req && instr_done) begin
        pc_reg <= cpu_pc;
        cc_reg <= ccr_flags;
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_vec_len;
    vrd |-> gap_reg == plen;
  endproperty
  a_vec_len: assert property (p_vec_len)
    else $error("stacking phase length wrong");
  property p_fetch_gap;
    frd |-> gap_reg == plen + 5'h02;
  endproperty
  a_fetch_gap: assert property (p_fetch_gap)
    else $error("vector phase plus internal states wrong");
  property p_go_len;
    cpu_out.handler_go |-> gap_reg == plen;
  endproperty
  a_go_len: assert property (p_go_len)
    else $error("fetch phase length wrong");
  property p_single;
    $rose(req) && !nmi && sc_reg[0] |-> !$past(ccr_flags[0]);
  endproperty
  a_single: assert property (p_single)
    else $error("maskable accepted with global mask set");
  property p_two;
    $rose(req) && !nmi && !sc_reg[0] |-> $past(ccr_flags) != 2'h3;
  endproperty
  a_two: assert property (p_two)
    else $error("maskable accepted with both masks set");
  property p_mask_set;
    vrd |=> ccr_flags[0] && (sc_reg[0] || ccr_flags[1]);
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("mask flags not raised after stacking");
  property p_stack;
    stk |-> cpu_out.stack_pc == pc_reg &&
      cpu_out.stack_ccr == {6'h00, cc_reg};
  endproperty
  a_stack: assert property (p_stack)
    else $error("stacked counter or flags wrong");
  property p_vaddr;
    vrd && sc_reg[1] |-> cpu_out.vec_addr ==
      {8'h00, cpu_out.ack_vec, 2'h0};
  endproperty
  a_vaddr: assert property (p_vaddr)
    else $error("vector address wrong");
  property p_hold;
    req && !instr_done |=> req && !stk;
  endproperty
  a_hold: assert property (p_hold)
    else $error("request dropped before instruction end");
  property p_standby;
    $rose(req) && nmi |-> !$past(hw_standby);
  endproperty
  a_standby: assert property (p_standby)
    else $error("nonmaskable accepted in standby");
  property p_src;
    $rose(req) && !nmi |-> picu_pkg::VALID_SRC[cpu_out.ack_vec];
  endproperty
  a_src: assert property (p_src)
    else $error("reserved vector served");
  c_nmi: cover property ($rose(req) && nmi);
  c_two: cover property (vrd && !sc_reg[0]);
  c_wait: cover property (cpu_out.handler_go && sc_reg[7:4] != 4'h0);
endmodule

// >>> sim/picu_core_model.sv
// picu_core_model: cpu core facing the controller.
// Assumes pulses on cpu_out last one cycle; answers delay+1 cycles after int_req.
`timescale 1ns/1ps
module picu_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller side
  input wire picu_pkg::picu_cpu_out_t cpu_out,
  input wire logic [2:0] delay,
  output logic instr_done,
  output logic [23:0] cpu_pc,
  output logic [23:0] vec_rdata
);
  logic [2:0] cnt_reg;
  logic vec_on_reg;
  wire busy = cpu_out.int_req && !instr_done;
  wire done_next = busy && cnt_reg == delay;
  wire vec_on = cpu_out.vec_rd || vec_on_reg;
  // instruction ends delay+1 cycles after int_req rises; pc runs so capture time matters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 3'h0;
      instr_done <= 1'b0;
      cpu_pc <= 24'h000100;
    end else begin
      cnt_reg <= (busy && !done_next) ? cnt_reg + 3'h1 : 3'h0;
      instr_done <= done_next;
      cpu_pc <= cpu_pc + 24'h000002;
    end
  end
  // vector data valid from the vector read until the fetch pulse, toggles elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_on_reg <= 1'b0;
      vec_rdata <= 24'h000000;
    end else begin
      vec_on_reg <= vec_on && !cpu_out.fetch_rd;
      vec_rdata <= vec_on ? {8'hA5, cpu_out.vec_addr} : ~vec_rdata;
    end
  end
endmodule

// >>> sim/picu_top_tb.sv
// picu_top_tb: self-checking bench for the interrupt controller.
// Assumes the core model answers int_req; apb answers without waits.
`timescale 1ns/1ps
module picu_top_tb;
  logic pclk, presetn, psel, penable, pwrite, nmi_pin, hw_standby;
  logic pready, pslverr, err, instr_done, mode, hit;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [5:0] irq_pin, v;
  logic [63:0] periph_req;
  logic [23:0] cpu_pc, vec_rdata;
  logic [2:0] core_delay;
  logic [1:0] ccr_flags;
  picu_pkg::picu_cpu_out_t cpu_out;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int plen, w;

  picu_top picu_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .nmi_pin, .irq_pin, .periph_req,
    .hw_standby, .instr_done, .cpu_pc, .vec_rdata, .cpu_out, .ccr_flags);
  picu_core_model picu_core_model_i (.pclk, .presetn, .cpu_out,
    .delay(core_delay), .instr_done, .cpu_pc, .vec_rdata);

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // hang guard; the whole run needs about a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  task final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic int acc_len(input int m);
    return m == 0 ? 4 : m == 1 ? 6 : m == 2 ? 8 : 12;
  endfunction
  // one apb transfer; holds everything until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task set_src(input logic [5:0] s, input logic on);
    @(posedge pclk);
    if (s == picu_pkg::VEC_NMI) nmi_pin <= on;
    else if (s < 6'h12) irq_pin[s - 6'h0C] <= on;
    else periph_req[s] <= on;
  endtask
  // ten cycles in which nothing may be taken
  task quiet();
    hit = 1'b0;
    repeat (10) begin
      @(negedge pclk);
      hit = hit | cpu_out.int_req;
    end
    check(32'(hit), 32'h0);
  endtask
  // follow one service; dec is the decision length, 0 skips that check
  task serve(input logic [5:0] s, input int dec, input logic [1:0] back);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (cpu_out.int_req !== 1'b1 && n < 60);
    if (dec > 0) check(32'(n), 32'(dec + 2));
    check(32'(cpu_out.ack_vec), 32'(s));
    while (cpu_out.stack_wr !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    while (cpu_out.handler_go !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    check(32'(n), 32'(3 * plen + 2));
    check(32'(cpu_out.handler_addr), {8'hA5, 8'h00, s, 2'h0});
    check(32'(ccr_flags), mode ? 32'h1 : 32'h3);
    set_src(s, 1'b0);
    apb(1'b1, picu_pkg::REG_CCR, 32'(back));
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    nmi_pin = 1'b0;
    hw_standby = 1'b0;
    irq_pin = 6'h00;
    periph_req = 64'h0;
    core_delay = 3'h0;
    mode = 1'b1;
    plen = 4;
    void'($urandom(32'h553B));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then an unmapped word
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, i == 0 ? 32'h3 : i == 1 ? 32'h1 : 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    check(32'(err), 32'h1);
    // enable gating, then global mask, then release of the held request
    apb(1'b1, picu_pkg::REG_CCR, 32'h0);
    set_src(6'h35, 1'b1);
    quiet();
    apb(1'b1, picu_pkg::REG_CCR, 32'h1);
    apb(1'b1, picu_pkg::REG_EN_LO, picu_pkg::VALID_SRC[31:0]);
    apb(1'b1, picu_pkg::REG_EN_HI, picu_pkg::VALID_SRC[63:32]);
    quiet();
    apb(1'b1, picu_pkg::REG_CCR, 32'h0);
    serve(6'h35, 0, 2'h0);
    // each serial source alone, core answering at random speed
    for (int i = 0; i < 8; i++) begin
      core_delay <= 3'($urandom % 8);
      set_src(6'(6'h34 + i), 1'b1);
      serve(6'(6'h34 + i), 1, 2'h0);
    end
    // two serial channels at once, default order then level 1
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, picu_pkg::REG_PRIO_B, k ? 32'h4 : 32'h0);
      @(posedge pclk);
      periph_req <= periph_req | 64'h0110_0000_0000_0000;
      serve(k ? 6'h38 : 6'h34, 0, 2'h0);
      serve(k ? 6'h34 : 6'h38, 0, 2'h0);
    end
    // two-bit masking: level 1 passes the global flag, level 0 waits
    mode = 1'b0;
    apb(1'b1, picu_pkg::REG_SYSCTL, 32'h2);
    apb(1'b1, picu_pkg::REG_CCR, 32'h1);
    @(posedge pclk);
    periph_req <= periph_req | 64'h0210_0000_0000_0000;
    serve(6'h39, 0, 2'h1);
    quiet();
    apb(1'b1, picu_pkg::REG_CCR, 32'h0);
    serve(6'h34, 0, 2'h0);
    // nonmaskable despite the mask, refused in standby
    mode = 1'b1;
    apb(1'b1, picu_pkg::REG_SYSCTL, 32'h3);
    apb(1'b1, picu_pkg::REG_CCR, 32'h1);
    set_src(picu_pkg::VEC_NMI, 1'b1);
    serve(picu_pkg::VEC_NMI, 0, 2'h1);
    hw_standby <= 1'b1;
    set_src(picu_pkg::VEC_NMI, 1'b1);
    quiet();
    set_src(picu_pkg::VEC_NMI, 1'b0);
    hw_standby <= 1'b0;
    // pins over every memory type with random wait states
    apb(1'b1, picu_pkg::REG_CCR, 32'h0);
    for (int m = 0; m < 4; m++) begin
      w = $urandom % 4;
      apb(1'b1, picu_pkg::REG_SYSCTL, 32'(16 * w + 4 * m + 3));
      plen = acc_len(m) + w;
      v = 6'(6'h0C + $urandom % 6);
      set_src(v, 1'b1);
      serve(v, 2, 2'h0);
    end
    final_report();
  end
endmodule

bind picu_top picu_monitor picu_monitor_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .hw_standby, .instr_done, .cpu_pc,
  .cpu_out, .ccr_flags);
